//--- phpcs_pkg.sv
// Constants for the PHY port control and status register bank
package phpcs_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_MII_CTRL = 8'he4;
	localparam logic [7:0] IDX_ADVERT = 8'hec;
	localparam logic [7:0] IDX_PARTNER = 8'hee;
	localparam logic [7:0] IDX_RSV_LO = 8'hf0;
	localparam logic [7:0] IDX_RSV_HI = 8'hf3;
	localparam logic [7:0] IDX_SPECIAL = 8'hf4;
	localparam logic [7:0] IDX_PORT_CTRL = 8'hf6;
	localparam logic [7:0] IDX_PORT_STAT = 8'hf8;
	// ==========================================================
	// Port control field positions
	localparam int PC_LED_OFF = 15, PC_TX_DIS = 14, PC_RESTART = 13, PC_MDIX_DIS = 10;
	localparam int PC_FORCE_MDIX = 9, PC_AN_EN = 7, PC_SPEED = 6, PC_DUPLEX = 5;
	// Mii basic control field positions
	localparam int MC_SPEED = 13, MC_AN_EN = 12, MC_RESTART = 9, MC_DUPLEX = 8;
	localparam int MC_FORCE_MDIX = 4, MC_MDIX_DIS = 3, MC_TX_DIS = 1, MC_LED_OFF = 0;
	// Special control field positions
	localparam int SC_RESULT_LO = 13, SC_TEST_EN = 12, SC_FORCE_LINK = 11, SC_LOOPBACK = 9;
	// Port status field positions
	localparam int PS_SPEED = 10, PS_DUPLEX = 9, PS_MDI = 7, PS_AN_DONE = 6, PS_LINK = 5;
	// Pause bit in partner and advertisement views, low ability bit
	localparam int AB_PAUSE = 10, AB_LO = 5;
	// ==========================================================
	// Reset and fixed values
	localparam logic [15:0] PC_RESET = 16'h00ff;
	// Port control bits that a write may change, reserved 12, 11, 8 excluded
	localparam logic [15:0] PC_WRITE_MASK = 16'he6ff;
	localparam logic [4:0] SELECTOR = 5'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Cable fault distance per count in millimetres
	localparam int FAULT_MM_PER_COUNT = 400;
endpackage : phpcs_pkg

//--- phpcs_regs.sv
// PHY port control and status register bank with AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module phpcs_regs
	import phpcs_pkg::*;
#(
	parameter int ADDR_W = 10 // Byte address width
) (
	input wire logic CLK_IN, // System clock
	input wire logic RESET_IN, // Asynchronous reset
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN, // Write address
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN, // Write data
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT, // Write response
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN, // Read address
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT, // Read data
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic [4:0] PARTNER_ABILITY_IN, // Pause, 100F, 100H, 10F, 10H
	input wire logic LINK_GOOD_IN, // Link up
	input wire logic AN_DONE_IN, // Negotiation complete
	input wire logic AN_FAILED_IN, // Negotiation failed
	input wire logic AN_SPEED_100_IN, // Negotiated speed
	input wire logic AN_FULL_DUPLEX_IN, // Negotiated duplex
	input wire logic MDI_STATUS_IN, // One for MDI, zero for MDI-X
	input wire logic CABLE_TEST_DONE_IN, // Test finished pulse
	input wire logic [1:0] CABLE_RESULT_IN, // Result with done
	input wire logic [8:0] FAULT_COUNT_IN, // Distance with done
	input wire logic [3:0] LED_STATUS_IN, // Normal LED drive
	output logic [3:0] PORT_LED_PIN_OUT, // LED pins
	output logic FORCE_LINK_OUT,
	output logic REMOTE_LOOPBACK_OUT,
	output logic TX_DISABLE_OUT,
	output logic AN_ENABLE_OUT,
	output logic AN_RESTART_OUT, // One-cycle pulse
	output logic AUTO_MDIX_OUT, // Automatic crossover active
	output logic FORCE_MDIX_OUT,
	output logic SPEED_100_OUT, // Resolved speed
	output logic FULL_DUPLEX_OUT, // Resolved duplex
	output logic [4:0] ADVERT_OUT, // Advertised abilities
	output logic CABLE_TEST_START_OUT // One-cycle pulse
);
	// ==========================================================
	// Parameter check
	// Refused at elaboration, the decode needs bits 9:2
	if (ADDR_W < 10 || ADDR_W > 16) begin : g_bad_addr_w
		$error("ADDR_W must be 10 to 16");
	end

	// ==========================================================
	// Storage
	logic [15:0] port_control; // Port control bits
	logic test_en; // Cable test running
	logic force_link; // Force link pass
	logic loopback; // Remote loopback
	logic [1:0] cable_result; // Last result
	logic [8:0] fault_count; // Last fault distance
	logic [15:0] next_port_control; // Control after write
	logic next_force_link;
	logic next_loopback;
	logic test_set; // Write sets test enable
	// Bus handshake state
	logic aw_full; // Address held
	logic w_full; // Data held
	logic [7:0] aw_idx; // Held register index
	logic [31:0] w_data; // Held write data
	logic [3:0] w_strb; // Held strobes
	logic do_write; // Commit write this cycle
	logic ar_take; // Read taken this cycle
	logic [7:0] ar_idx; // Read register index
	// Register views
	logic [15:0] partner_view;
	logic [15:0] special_view;
	logic [15:0] status_view;
	logic [15:0] mii_view;
	logic [15:0] advert_view;
	logic [15:0] wview; // View under write
	logic [15:0] wmerged; // View with strobes applied
	logic [15:0] rview; // View under read
	logic rhit; // Read address mapped
	logic whit; // Write address mapped

	// ==========================================================
	// Views of the storage
	always_comb begin
		partner_view = 16'h0000;
		partner_view[AB_PAUSE] = PARTNER_ABILITY_IN[4];
		partner_view[AB_LO+3:AB_LO] = PARTNER_ABILITY_IN[3:0];
		partner_view[4:0] = SELECTOR;
		special_view = 16'h0000;
		special_view[SC_RESULT_LO+1:SC_RESULT_LO] = cable_result;
		special_view[SC_TEST_EN] = test_en;
		special_view[SC_FORCE_LINK] = force_link;
		special_view[SC_LOOPBACK] = loopback;
		special_view[8:0] = fault_count;
		status_view = 16'h0000;
		status_view[PS_SPEED] = SPEED_100_OUT;
		status_view[PS_DUPLEX] = FULL_DUPLEX_OUT;
		status_view[PS_MDI] = MDI_STATUS_IN;
		status_view[PS_AN_DONE] = AN_DONE_IN;
		status_view[PS_LINK] = LINK_GOOD_IN;
		status_view[4:0] = PARTNER_ABILITY_IN;
		// basic control alias of port control
		mii_view = 16'h0000;
		mii_view[MC_SPEED] = port_control[PC_SPEED];
		mii_view[MC_AN_EN] = port_control[PC_AN_EN];
		mii_view[MC_RESTART] = port_control[PC_RESTART];
		mii_view[MC_DUPLEX] = port_control[PC_DUPLEX];
		mii_view[MC_FORCE_MDIX] = port_control[PC_FORCE_MDIX];
		mii_view[MC_MDIX_DIS] = port_control[PC_MDIX_DIS];
		mii_view[MC_TX_DIS] = port_control[PC_TX_DIS];
		mii_view[MC_LED_OFF] = port_control[PC_LED_OFF];
		advert_view = 16'h0000;
		advert_view[AB_PAUSE] = port_control[4];
		advert_view[AB_LO+3:AB_LO] = port_control[3:0];
		advert_view[4:0] = SELECTOR;
	end

	// ==========================================================
	// Address decode
	always_comb begin
		ar_idx = S_AXI_ARADDR_IN[9:2];
		rhit = 1'b1;
		case (ar_idx)
			IDX_MII_CTRL: rview = mii_view;
			IDX_ADVERT: rview = advert_view;
			IDX_PARTNER: rview = partner_view;
			IDX_SPECIAL: rview = special_view;
			IDX_PORT_CTRL: rview = port_control;
			IDX_PORT_STAT: rview = status_view;
			// reserved range and all else unmapped
			default: begin
				rview = 16'h0000;
				rhit = 1'b0;
			end
		endcase
		whit = 1'b1;
		case (aw_idx)
			IDX_MII_CTRL: wview = mii_view;
			IDX_ADVERT: wview = advert_view;
			IDX_PARTNER: wview = partner_view;
			IDX_SPECIAL: wview = special_view;
			IDX_PORT_CTRL: wview = port_control;
			IDX_PORT_STAT: wview = status_view;
			default: begin
				wview = 16'h0000;
				whit = 1'b0;
			end
		endcase
		// Byte lanes 0 and 1 carry the low and high bytes
		wmerged[7:0] = w_strb[0] ? w_data[7:0] : wview[7:0];
		wmerged[15:8] = w_strb[1] ? w_data[15:8] : wview[15:8];
	end

	// ==========================================================
	// Field update from a committed write
	always_comb begin
		next_port_control = port_control;
		next_force_link = force_link;
		next_loopback = loopback;
		test_set = 1'b0;
		if (do_write) begin
			case (aw_idx)
				IDX_PORT_CTRL: begin
					// reserved bits 12, 11, 8 stay zero
					next_port_control = wmerged & PC_WRITE_MASK;
				end
				IDX_MII_CTRL: begin
					next_port_control[PC_SPEED] = wmerged[MC_SPEED];
					next_port_control[PC_AN_EN] = wmerged[MC_AN_EN];
					next_port_control[PC_RESTART] = wmerged[MC_RESTART];
					next_port_control[PC_DUPLEX] = wmerged[MC_DUPLEX];
					next_port_control[PC_FORCE_MDIX] = wmerged[MC_FORCE_MDIX];
					next_port_control[PC_MDIX_DIS] = wmerged[MC_MDIX_DIS];
					next_port_control[PC_TX_DIS] = wmerged[MC_TX_DIS];
					next_port_control[PC_LED_OFF] = wmerged[MC_LED_OFF];
				end
				IDX_ADVERT: begin
					next_port_control[4] = wmerged[AB_PAUSE];
					next_port_control[3:0] = wmerged[AB_LO+3:AB_LO];
				end
				IDX_SPECIAL: begin
					next_force_link = wmerged[SC_FORCE_LINK];
					next_loopback = wmerged[SC_LOOPBACK];
					test_set = wmerged[SC_TEST_EN] & w_strb[1];
				end
				default: next_port_control = port_control;
			endcase
		end
	end

	// ==========================================================
	// Control register storage
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			port_control <= PC_RESET;
			force_link <= 1'b0;
			loopback <= 1'b0;
		end else begin
			port_control <= next_port_control;
			// restart bit clears the cycle after it is set, as its pulse starts, new write wins
			if (port_control[PC_RESTART] && !(do_write && next_port_control[PC_RESTART]))
				port_control[PC_RESTART] <= 1'b0;
			force_link <= next_force_link;
			loopback <= next_loopback;
		end
	end

	// ==========================================================
	// Cable test state and results
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			test_en <= 1'b0;
			cable_result <= 2'h0;
			fault_count <= 9'h000;
		end else begin
			// results latched as the enable drops
			if (test_en && CABLE_TEST_DONE_IN) begin
				cable_result <= CABLE_RESULT_IN;
				fault_count <= FAULT_COUNT_IN;
			end
			// self-clear on done, a new start wins
			if (test_set)
				test_en <= 1'b1;
			else if (CABLE_TEST_DONE_IN)
				test_en <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs toward the PHY core
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PORT_LED_PIN_OUT <= 4'h0;
			FORCE_LINK_OUT <= 1'b0;
			REMOTE_LOOPBACK_OUT <= 1'b0;
			TX_DISABLE_OUT <= 1'b0;
			AN_ENABLE_OUT <= 1'b0;
			AN_RESTART_OUT <= 1'b0;
			AUTO_MDIX_OUT <= 1'b0;
			FORCE_MDIX_OUT <= 1'b0;
			SPEED_100_OUT <= 1'b0;
			FULL_DUPLEX_OUT <= 1'b0;
			ADVERT_OUT <= 5'h00;
			CABLE_TEST_START_OUT <= 1'b0;
		end else begin
			PORT_LED_PIN_OUT <= port_control[PC_LED_OFF] ? 4'hf : LED_STATUS_IN;
			FORCE_LINK_OUT <= force_link;
			REMOTE_LOOPBACK_OUT <= loopback;
			TX_DISABLE_OUT <= port_control[PC_TX_DIS];
			AN_ENABLE_OUT <= port_control[PC_AN_EN];
			AN_RESTART_OUT <= port_control[PC_RESTART];
			AUTO_MDIX_OUT <= ~port_control[PC_MDIX_DIS];
			// force only when automatic is off
			FORCE_MDIX_OUT <= port_control[PC_MDIX_DIS] & port_control[PC_FORCE_MDIX];
			SPEED_100_OUT <= port_control[PC_AN_EN] ? AN_SPEED_100_IN : port_control[PC_SPEED];
			// forced duplex when off or failed
			FULL_DUPLEX_OUT <= (port_control[PC_AN_EN] && !AN_FAILED_IN) ?
				AN_FULL_DUPLEX_IN : port_control[PC_DUPLEX];
			ADVERT_OUT <= port_control[4:0];
			CABLE_TEST_START_OUT <= test_set;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel
	assign S_AXI_AWREADY_OUT = ~aw_full & ~S_AXI_BVALID_OUT;
	assign S_AXI_WREADY_OUT = ~w_full & ~S_AXI_BVALID_OUT;
	assign do_write = aw_full & w_full & ~S_AXI_BVALID_OUT;

	// Address and data held in either order, then committed
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_idx <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_full <= 1'b1;
				aw_idx <= S_AXI_AWADDR_IN[9:2];
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_full <= 1'b1;
				w_data <= S_AXI_WDATA_IN;
				w_strb <= S_AXI_WSTRB_IN;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= whit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;
	assign ar_take = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

	// Read data registered one cycle after the address
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0000_0000;
			S_AXI_RRESP_OUT <= RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RDATA_OUT <= {16'h0000, rview};
			S_AXI_RRESP_OUT <= rhit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY_IN) begin
			S_AXI_RVALID_OUT <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	chk_partner_read: assert property (
		ar_take && ar_idx == IDX_PARTNER |=> S_AXI_RDATA_OUT[15:13] == 3'h0 &&
		S_AXI_RDATA_OUT[AB_PAUSE] == $past(PARTNER_ABILITY_IN[4]) &&
		S_AXI_RDATA_OUT[8:5] == $past(PARTNER_ABILITY_IN[3:0]))
		else $error("Partner ability read wrong");
	chk_status_mirror: assert property (
		ar_take && ar_idx == IDX_PORT_STAT |=>
		S_AXI_RDATA_OUT[4:0] == $past(PARTNER_ABILITY_IN))
		else $error("Status partner bits do not mirror");
	chk_test_clear: assert property (
		test_en && CABLE_TEST_DONE_IN && !test_set |=> !test_en && cable_result ==
		$past(CABLE_RESULT_IN) && fault_count == $past(FAULT_COUNT_IN))
		else $error("Cable test did not complete");
	chk_test_start: assert property (
		test_set |=> test_en && CABLE_TEST_START_OUT)
		else $error("Cable test did not start");
	chk_led_off: assert property (
		port_control[PC_LED_OFF] |=> PORT_LED_PIN_OUT == 4'hf)
		else $error("LED pins not high while off");
	chk_mdix_force: assert property (
		FORCE_MDIX_OUT |-> !AUTO_MDIX_OUT && $past(port_control[PC_FORCE_MDIX]))
		else $error("MDI-X forced while automatic");
	chk_forced_speed: assert property (
		!port_control[PC_AN_EN] ##1 !port_control[PC_AN_EN] |->
		SPEED_100_OUT == $past(port_control[PC_SPEED]))
		else $error("Forced speed not applied");
	chk_fail_duplex: assert property (
		AN_FAILED_IN |=> FULL_DUPLEX_OUT == $past(port_control[PC_DUPLEX]))
		else $error("Duplex not forced on failure");
	chk_alias_led: assert property (
		do_write && aw_idx == IDX_MII_CTRL && w_strb[0] |=>
		port_control[PC_LED_OFF] == $past(w_data[MC_LED_OFF]))
		else $error("Basic control alias not applied");
	chk_reserved_rsp: assert property (
		ar_take && ar_idx >= IDX_RSV_LO && ar_idx <= IDX_RSV_HI |=>
		S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == RESP_SLVERR)
		else $error("Reserved range answered as mapped");
	chk_restart_pulse: assert property (
		AN_RESTART_OUT && !port_control[PC_RESTART] |=> !AN_RESTART_OUT)
		else $error("Restart pulse too long");

	cov_cable_test: cover property (test_set ##[1:50] (test_en && CABLE_TEST_DONE_IN));
	cov_write_alias: cover property (do_write && aw_idx == IDX_ADVERT);
	cov_read_partner: cover property (ar_take && ar_idx == IDX_PARTNER);
	cov_restart: cover property (AN_RESTART_OUT);
endmodule : phpcs_regs
`default_nettype wire

//--- phpcs_phy_model.sv
// Behavioural PHY core that answers cable diagnostic tests
`timescale 1ns/1ns
`default_nettype none
module phpcs_phy_model (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic start_in, // Test start pulse
	input wire logic [1:0] res_in, // Result to report
	input wire logic [8:0] cnt_in, // Fault count to report
	input wire logic [7:0] delay_in, // Cycles until done, not zero
	output logic done_out, // Done pulse
	output logic [1:0] res_out, // Valid with done only
	output logic [8:0] cnt_out // Valid with done only
);
	logic [7:0] left; // Cycles until done
	logic busy; // Test in progress
	logic hit; // Last cycle of test
	assign hit = busy && (left == 8'h01);
	// ==========================================================
	// Cable test timing
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			busy <= 1'b0;
			left <= 8'h00;
			done_out <= 1'b0;
			res_out <= 2'h0;
			cnt_out <= 9'h000;
		end else begin
			done_out <= hit;
			// Stale data toggles so it is never mistaken for a result
			if (hit) begin
				res_out <= res_in;
				cnt_out <= cnt_in;
			end else begin
				res_out <= ~res_out;
				cnt_out <= ~cnt_out;
			end
			// Start wins over countdown
			if (start_in) begin
				busy <= 1'b1;
				left <= delay_in;
			end else if (busy) begin
				left <= left - 8'h01;
				busy <= !hit;
			end
		end
	end
endmodule : phpcs_phy_model
`default_nettype wire

//--- phy_port_control_status_regs_bench.sv
// Self-checking bench for the PHY port register bank
`timescale 1ns/1ns
`default_nettype none
module phy_port_control_status_regs_bench;
	import phpcs_pkg::*;
	// ==========================================================
	// Clock, reset, bus and PHY signals
	logic clk = 1'b0;
	logic rst;
	logic [9:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, led_st, led_pin;
	logic [1:0] bresp, rresp, m_res, res_ph;
	logic [4:0] pab, advert;
	logic link, an_done, an_fail, an_spd, an_fdx, mdi, done;
	logic [8:0] m_cnt, cnt_ph;
	logic [7:0] m_dly;
	logic f_link, rlb, tx_dis, an_en, an_rst, auto_x, force_x, spd, fdx, t_start;
	logic [15:0] rdat; // Last read data
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int n_rst = 0; // Restart pulses seen
	int n_start = 0; // Test start pulses seen
	always #10 clk = ~clk;
	phpcs_regs u_phpcs_regs (.CLK_IN(clk), .RESET_IN(rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .PARTNER_ABILITY_IN(pab),
		.LINK_GOOD_IN(link), .AN_DONE_IN(an_done), .AN_FAILED_IN(an_fail),
		.AN_SPEED_100_IN(an_spd), .AN_FULL_DUPLEX_IN(an_fdx), .MDI_STATUS_IN(mdi),
		.CABLE_TEST_DONE_IN(done), .CABLE_RESULT_IN(res_ph), .FAULT_COUNT_IN(cnt_ph),
		.LED_STATUS_IN(led_st), .PORT_LED_PIN_OUT(led_pin), .FORCE_LINK_OUT(f_link),
		.REMOTE_LOOPBACK_OUT(rlb), .TX_DISABLE_OUT(tx_dis), .AN_ENABLE_OUT(an_en),
		.AN_RESTART_OUT(an_rst), .AUTO_MDIX_OUT(auto_x), .FORCE_MDIX_OUT(force_x),
		.SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx), .ADVERT_OUT(advert),
		.CABLE_TEST_START_OUT(t_start));
	phpcs_phy_model u_phpcs_phy_model (.clk_in(clk), .reset_in(rst), .start_in(t_start),
		.res_in(m_res), .cnt_in(m_cnt), .delay_in(m_dly), .done_out(done),
		.res_out(res_ph), .cnt_out(cnt_ph));
	// ==========================================================
	// Timeout and pulse counting
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
		if (an_rst === 1'b1) n_rst++;
		if (t_start === 1'b1) n_start++;
	end
	// ==========================================================
	// Shared tasks
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk
	task wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			// Each channel released at its own handshake
			if (awready === 1'b1 && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr
	task rd(input logic [7:0] idx, input logic [1:0] er);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rdat = rdata[15:0];
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd
	task rdc(input logic [7:0] idx, input logic [15:0] exp, input string nm);
		rd(idx, RESP_OKAY);
		chk(nm, {16'h0, exp}, {16'h0, rdat});
	endtask : rdc
	// ==========================================================
	// Scenarios
	task t_reset;
		rdc(IDX_PORT_CTRL, PC_RESET, "port_control");
		rdc(IDX_SPECIAL, 16'h0000, "special");
		chk("an_enable", 1, an_en);
		chk("advert", 5'h1f, advert);
	endtask : t_reset
	task t_partner;
		logic [4:0] pv[2];
		pv = '{5'h15, 5'h0a};
		{link, an_done, mdi} <= 3'h7;
		foreach (pv[i]) begin
			pab <= pv[i];
			wr(IDX_PARTNER, 16'hffff, RESP_OKAY);
			rdc(IDX_PARTNER, {5'h00, pv[i][4], 1'b0, pv[i][3:0], SELECTOR}, "partner");
			rd(IDX_PORT_STAT, RESP_OKAY);
			chk("status_partner", pv[i], rdat[4:0]);
			chk("status", {8'h00, 3'h7, pv[i]}, rdat);
		end
	endtask : t_partner
	task t_ctrl;
		wr(IDX_PORT_CTRL, 16'hdf2a, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("led_pin", 4'hf, led_pin);
		chk("tx_disable", 1, tx_dis);
		chk("auto_mdix", 0, auto_x);
		chk("force_mdix", 1, force_x);
		chk("an_enable", 0, an_en);
		chk("speed", 0, spd);
		chk("duplex", 1, fdx);
		chk("advert", 5'h0a, advert);
		rdc(IDX_PORT_CTRL, 16'hc62a, "port_control");
		rdc(IDX_MII_CTRL, 16'h011b, "mii_ctrl");
		rdc(IDX_ADVERT, 16'h0141, "advert_reg");
		wr(IDX_MII_CTRL, 16'h3010, RESP_OKAY);
		an_fail <= 1'b1;
		an_fdx <= 1'b1;
		repeat (2) @(posedge clk);
		rdc(IDX_PORT_CTRL, 16'h02ca, "port_control");
		chk("led_pin", led_st, led_pin);
		chk("auto_mdix", 1, auto_x);
		chk("force_mdix", 0, force_x);
		chk("speed", 0, spd);
		chk("duplex", 0, fdx);
		an_fail <= 1'b0;
		repeat (2) @(posedge clk);
		chk("duplex", 1, fdx);
		wr(IDX_PORT_CTRL, 16'h0040, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("speed", 1, spd);
		chk("duplex", 0, fdx);
		chk("advert", 5'h00, advert);
	endtask : t_ctrl
	task t_restart;
		int base; // Pulses seen before this scenario
		base = n_rst;
		wr(IDX_PORT_CTRL, 16'h22ca, RESP_OKAY);
		repeat (4) @(posedge clk);
		chk("restart_pulses", 1, n_rst - base);
		rdc(IDX_PORT_CTRL, 16'h02ca, "port_control");
	endtask : t_restart
	task t_cable;
		int k;
		int base; // Start pulses seen before this test
		for (int c = 0; c < 4; c++) begin
			base = n_start;
			m_res <= c[1:0];
			m_cnt <= (c == 3) ? 9'h1ff : 9'(c * 37);
			m_dly <= 8'(8 + c * 40);
			wr(IDX_SPECIAL, 16'h1000, RESP_OKAY);
			rd(IDX_SPECIAL, RESP_OKAY);
			chk("test_running", 1, rdat[12]);
			k = 0;
			do begin
				rd(IDX_SPECIAL, RESP_OKAY);
				k++;
			end while (rdat[12] !== 1'b0 && k < 100);
			chk("cable_result", {1'b0, c[1:0], 4'h0, m_cnt}, rdat);
			chk("start_pulses", 1, n_start - base);
		end
		wr(IDX_SPECIAL, 16'h0a00, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("force_link", 1, f_link);
		chk("loopback", 1, rlb);
		rdc(IDX_SPECIAL, 16'h6bff, "special");
		wr(IDX_SPECIAL, 16'h0000, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("force_link", 0, f_link);
		chk("loopback", 0, rlb);
	endtask : t_cable
	task t_reserved;
		for (int a = IDX_RSV_LO; a <= IDX_RSV_HI; a++) begin
			wr(8'(a), 16'hffff, RESP_SLVERR);
			rd(8'(a), RESP_SLVERR);
			chk("reserved", 0, rdat);
		end
		rdc(IDX_PORT_CTRL, 16'h02ca, "port_control");
	endtask : t_reserved
	task stop_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{pab, link, an_done, an_fail, an_spd, an_fdx, mdi, m_res, m_cnt} = '0;
		wstrb = 4'h3;
		led_st = 4'h5;
		m_dly = 8'h08;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_partner();
		t_ctrl();
		t_restart();
		t_cable();
		t_reserved();
		stop_test();
	end
endmodule : phy_port_control_status_regs_bench
`default_nettype wire
